// ---- hsw_regs.vh ----
`ifndef HSW_REGS_VH
`define HSW_REGS_VH
// ==========================================================================
// Register indices of the command port.
`define HSW_ADDR_MODE      4'h0
`define HSW_ADDR_TCL       4'h1
`define HSW_ADDR_TCQ       4'h2
`define HSW_ADDR_GAIN      4'h3
`define HSW_ADDR_QOFS      4'h4
`define HSW_ADDR_LOW       4'h5
`define HSW_ADDR_HIGH      4'h6
`define HSW_ADDR_LOCK      4'h7
`define HSW_ADDR_SAMPLE    4'h8
`define HSW_ADDR_TRIM_OSC  4'h9
`define HSW_ADDR_TRIM_ADC  4'hA
`define HSW_ADDR_TRIM_SPC  4'hB
`define HSW_NV_LAST        4'hB
// ==========================================================================
// Field positions and widths.
`define HSW_RANGE_LSB      0
`define HSW_RANGE_MSB      2
`define HSW_FILT_LSB       3
`define HSW_FILT_MSB       5
`define HSW_MODE_W         6
`define HSW_COEF_W         8
`define HSW_GAIN_W         14
`define HSW_QOFS_W         11
`define HSW_LVL_W          12
`define HSW_SAMPLE_W       14
`define HSW_TRIM_W         8
`define HSW_DATA_W         16
// Gain of one is 2048, so the product is scaled down by 11 bits.
`define HSW_GAIN_FRAC      11
// ==========================================================================
// Reset values of the working registers, before the load from storage.
`define HSW_RST_MODE       6'h00
`define HSW_RST_GAIN       14'h0800
`define HSW_RST_WORD       16'h0000
// ==========================================================================
// Filter codes, filter time constants and clipping spans.
`define HSW_FILT_80        3'h0
`define HSW_FILT_160       3'h1
`define HSW_FILT_500       3'h2
`define HSW_FILT_1K        3'h3
`define HSW_SHIFT_80       4'h7
`define HSW_SHIFT_160      4'h6
`define HSW_SHIFT_500      4'h4
`define HSW_SHIFT_1K       4'h3
`define HSW_SHIFT_2K       4'h2
`define HSW_MIN_80         -16'sd3968
`define HSW_MAX_80         16'sd3967
`define HSW_MIN_160        -16'sd1985
`define HSW_MAX_160        16'sd1985
`define HSW_MIN_500        -16'sd5292
`define HSW_MAX_500        16'sd5290
`define HSW_MIN_1K         -16'sd2646
`define HSW_MAX_1K         16'sd2645
`define HSW_MIN_2K         -16'sd1512
`define HSW_MAX_2K         16'sd1511
// ==========================================================================
// Answer timing: cycles of ref_clk per answered bit.
`define HSW_ANS_BIT_CYC    16'd50
`define HSW_ANS_BITS       5'd16
`endif

// ---- hsw_dsp.v ----
// Notes on behaviour
// - Output goes low above upper threshold, high below lower threshold.
// - Processed signal is filtered sample times gain plus quiescent offset.
// - Quiescent offset equals the processed signal at zero sample.
// - Gain one adds a full supply span per 2048 sample counts.
// - Gain is signed, minus four to just under plus four, step 1/2048.
// - Low three configuration bits select the field range.
// - Range codes map 0,4,5,1,6,2,7,3 to 30..150 mT.
// - High three configuration bits select the low-pass corner.
// - Filter codes 0 to 4 give 80 Hz up to 2 kHz.
// - Filtered sample is clipped to a span set by the filter code.
// - North pole gives positive samples, south pole negative ones.
// - Readable sample is taken after the filter, before gain and offset.
// - A set lock refuses programming forever and is never cleared.
// - Unlocked, commands are decoded and executed, and reads are answered on the pin.
// - Normal switching output is suspended during a command exchange.
// - Factory trim registers read back but reject user writes.
// - Lower and upper thresholds are stored and writable parameters.
// - A newly set lock acts only after the next power cycle.
// - Readable filtered sample is 14 bits wide.
`timescale 1ns/1ps
`include "hsw_regs.vh"

module hsw_dsp #(
   parameter ANS_BIT_CYC = `HSW_ANS_BIT_CYC
) (
   input  wire                          ref_clk,        // Oscillator clock.
   input  wire                          rst_b,          // Power-on reset.
   input  wire signed [`HSW_SAMPLE_W-1:0] adc_sample,   // Converter word.
   input  wire                          adc_valid,      // New word strobe.
   input  wire                          comm_active,    // Exchange running.
   input  wire                          cmd_valid,      // Command strobe.
   input  wire                          cmd_write,      // One for a write.
   input  wire [3:0]                    cmd_addr,       // Register index.
   input  wire [`HSW_DATA_W-1:0]        cmd_wdata,      // Write data.
   output reg  [2:0]                    range_sel,      // Field range code.
   output reg  [7:0]                    range_mt,       // Range in mT.
   output reg  [`HSW_COEF_W-1:0]        tc_lin,         // Linear coeff.
   output reg  [`HSW_COEF_W-1:0]        tc_quad,        // Quadratic coeff.
   output reg  [`HSW_TRIM_W-1:0]        trim_osc,       // Oscillator trim.
   output reg  [`HSW_TRIM_W-1:0]        trim_adc,       // Converter trim.
   output reg  [`HSW_TRIM_W-1:0]        trim_spc,       // Special trim.
   output reg                           out_level,      // Output pin level.
   output wire                          ans_busy,       // Answer shifting.
   output wire                          loaded,         // Load finished.
   output reg                           lock_active     // Lock in force.
);

   // =======================================================================
   // State machine and storage.
   localparam [2:0] ST_LOAD = 3'b001;
   localparam [2:0] ST_RUN  = 3'b010;
   localparam [2:0] ST_ANS  = 3'b100;

   reg [2:0]                    state_q;
   reg [3:0]                    load_idx_q;
   reg [`HSW_DATA_W-1:0]        nv_mem [0:`HSW_NV_LAST];
   reg [`HSW_MODE_W-1:0]        mode_q;
   reg signed [`HSW_GAIN_W-1:0] gain_q;
   reg signed [`HSW_QOFS_W-1:0] qofs_q;
   reg [`HSW_LVL_W-1:0]         low_q;
   reg [`HSW_LVL_W-1:0]         high_q;
   reg signed [`HSW_SAMPLE_W-1:0] filt_q;
   reg signed [18:0]            signal_q;
   reg                          sw_q;
   reg [`HSW_DATA_W-1:0]        ans_shift_q;
   reg [4:0]                    ans_cnt_q;
   reg [15:0]                   ans_tmr_q;
   integer                      i;

   // Storage starts blank; it has no reset because it outlives power.
   initial begin
      for (i = 0; i <= `HSW_NV_LAST; i = i + 1) begin
         nv_mem[i] = `HSW_RST_WORD;
      end
   end

   // Status flags decode straight from the one-hot state register.
   // Keeping them combinational means the programmer sees the answer
   // phase in the same cycle the sequencer enters it.
   assign ans_busy = state_q[2];
   assign loaded   = ~state_q[0];

   wire [2:0] filt_sel = mode_q[`HSW_FILT_MSB:`HSW_FILT_LSB];
   // A command is only taken in the run state, so anything arriving while
   // storage loads or an answer shifts out is dropped without trace.
   wire cmd_take = state_q[1] & cmd_valid & ~lock_active;
   wire nv_wr = cmd_take & cmd_write;

   // =======================================================================
   // Field range code and its span, fed to the analog front end.
   always @* begin
      range_sel = mode_q[`HSW_RANGE_MSB:`HSW_RANGE_LSB];
      case (range_sel)
         3'h0:    range_mt = 8'h1E;
         3'h4:    range_mt = 8'h28;
         3'h5:    range_mt = 8'h3C;
         3'h1:    range_mt = 8'h4B;
         3'h6:    range_mt = 8'h50;
         3'h2:    range_mt = 8'h5A;
         3'h7:    range_mt = 8'h64;
         default: range_mt = 8'h96;
      endcase
   end

   // =======================================================================
   // Low-pass filter, a first-order recursion y += (x - y) >> k.
   // Codes above 4 are undefined and fall back to the 2 kHz setting.
   reg [3:0]         f_shift;
   reg signed [15:0] f_min;
   reg signed [15:0] f_max;
   always @* begin
      case (filt_sel)
         `HSW_FILT_80: begin
            f_shift = `HSW_SHIFT_80;
            f_min   = `HSW_MIN_80;
            f_max   = `HSW_MAX_80;
         end
         `HSW_FILT_160: begin
            f_shift = `HSW_SHIFT_160;
            f_min   = `HSW_MIN_160;
            f_max   = `HSW_MAX_160;
         end
         `HSW_FILT_500: begin
            f_shift = `HSW_SHIFT_500;
            f_min   = `HSW_MIN_500;
            f_max   = `HSW_MAX_500;
         end
         `HSW_FILT_1K: begin
            f_shift = `HSW_SHIFT_1K;
            f_min   = `HSW_MIN_1K;
            f_max   = `HSW_MAX_1K;
         end
         default: begin
            f_shift = `HSW_SHIFT_2K;
            f_min   = `HSW_MIN_2K;
            f_max   = `HSW_MAX_2K;
         end
      endcase
   end

   // The sign of the converter word is kept, north positive.
   wire signed [15:0] f_diff = {{2{adc_sample[13]}}, adc_sample}
                             - {{2{filt_q[13]}}, filt_q};
   wire signed [15:0] f_step = f_diff >>> f_shift;
   wire signed [15:0] f_sum  = {{2{filt_q[13]}}, filt_q} + f_step;
   reg signed [15:0]  f_clip;
   always @* begin
      if (f_sum > f_max) begin
         f_clip = f_max;
      end else if (f_sum < f_min) begin
         f_clip = f_min;
      end else begin
         f_clip = f_sum;
      end
   end

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         filt_q <= 14'h0000;
      end else if (adc_valid) begin
         filt_q <= f_clip[13:0];
      end
   end

   // =======================================================================
   // Scaling: signal in steps of a 2048th of the supply span.
   // The offset counts in 1024ths, hence the doubling.
   wire signed [27:0] prod   = gain_q * filt_q;
   wire signed [16:0] scaled = prod[27:11];
   wire signed [18:0] sig_d  = {{2{scaled[16]}}, scaled}
                             + {{7{qofs_q[10]}}, qofs_q, 1'b0};
   // The sum keeps two spare bits, so extreme gain and offset settings
   // cannot wrap around and flip the comparator decision.

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         signal_q <= 19'h00000;
      end else begin
         signal_q <= sig_d;
      end
   end

   // =======================================================================
   // Hysteresis comparator; low means switched on.
   // The thresholds are unsigned, so a negative signal always lies below
   // the lower threshold and releases the switch.
   // The comparator is held off until the load has filled the thresholds.
   wire signed [18:0] hi_s = {7'h00, high_q};
   wire signed [18:0] lo_s = {7'h00, low_q};
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         sw_q <= 1'b1;
      end else if (!state_q[0]) begin
         if (signal_q > hi_s) begin
            sw_q <= 1'b0;
         end else if (signal_q < lo_s) begin
            sw_q <= 1'b1;
         end
      end
   end

   // =======================================================================
   // Main sequencer: load from storage, run, answer a read.
   reg [`HSW_DATA_W-1:0] rd_word;
   always @* begin
      case (cmd_addr)
         `HSW_ADDR_MODE:     rd_word = {10'h000, mode_q};
         `HSW_ADDR_TCL:      rd_word = {8'h00, tc_lin};
         `HSW_ADDR_TCQ:      rd_word = {8'h00, tc_quad};
         `HSW_ADDR_GAIN:     rd_word = {{2{gain_q[13]}}, gain_q};
         `HSW_ADDR_QOFS:     rd_word = {{5{qofs_q[10]}}, qofs_q};
         `HSW_ADDR_LOW:      rd_word = {4'h0, low_q};
         `HSW_ADDR_HIGH:     rd_word = {4'h0, high_q};
         `HSW_ADDR_LOCK:     rd_word = nv_mem[`HSW_ADDR_LOCK];
         `HSW_ADDR_SAMPLE:   rd_word = {{2{filt_q[13]}}, filt_q};
         `HSW_ADDR_TRIM_OSC: rd_word = {8'h00, trim_osc};
         `HSW_ADDR_TRIM_ADC: rd_word = {8'h00, trim_adc};
         `HSW_ADDR_TRIM_SPC: rd_word = {8'h00, trim_spc};
         default:            rd_word = `HSW_RST_WORD;
      endcase
   end

   // Storage write; trims, the sample and unmapped indices are refused.
   // The lock word can only gain its bit, never lose it.
   always @(posedge ref_clk) begin
      if (nv_wr) begin
         if (cmd_addr == `HSW_ADDR_LOCK) begin
            nv_mem[cmd_addr] <= {15'h0000,
                                 nv_mem[cmd_addr][0] | cmd_wdata[0]};
         end else if (cmd_addr < `HSW_ADDR_LOCK) begin
            nv_mem[cmd_addr] <= cmd_wdata;
         end
      end
   end

   wire [`HSW_DATA_W-1:0] ld_word = nv_mem[load_idx_q];
   wire wr_reg = nv_wr & (cmd_addr < `HSW_ADDR_LOCK);

   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q     <= ST_LOAD;
         load_idx_q  <= 4'h0;
         mode_q      <= `HSW_RST_MODE;
         tc_lin      <= 8'h00;
         tc_quad     <= 8'h00;
         gain_q      <= `HSW_RST_GAIN;
         qofs_q      <= 11'h000;
         low_q       <= 12'h000;
         high_q      <= 12'h000;
         trim_osc    <= 8'h00;
         trim_adc    <= 8'h00;
         trim_spc    <= 8'h00;
         lock_active <= 1'b0;
         ans_shift_q <= `HSW_RST_WORD;
         ans_cnt_q   <= 5'h00;
         ans_tmr_q   <= 16'h0000;
      end else begin
         case (state_q)
            ST_LOAD: begin
               load_idx_q <= load_idx_q + 4'h1;
               case (load_idx_q)
                  `HSW_ADDR_MODE:     mode_q   <= ld_word[5:0];
                  `HSW_ADDR_TCL:      tc_lin   <= ld_word[7:0];
                  `HSW_ADDR_TCQ:      tc_quad  <= ld_word[7:0];
                  `HSW_ADDR_GAIN:     gain_q   <= ld_word[13:0];
                  `HSW_ADDR_QOFS:     qofs_q   <= ld_word[10:0];
                  `HSW_ADDR_LOW:      low_q    <= ld_word[11:0];
                  `HSW_ADDR_HIGH:     high_q   <= ld_word[11:0];
                  `HSW_ADDR_LOCK:     lock_active <= ld_word[0];
                  `HSW_ADDR_TRIM_OSC: trim_osc <= ld_word[7:0];
                  `HSW_ADDR_TRIM_ADC: trim_adc <= ld_word[7:0];
                  `HSW_ADDR_TRIM_SPC: trim_spc <= ld_word[7:0];
                  default:            trim_spc <= trim_spc;
               endcase
               if (load_idx_q == `HSW_NV_LAST) begin
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               // Writes below the lock index act at once on the working copy too.
               if (wr_reg) begin
                  case (cmd_addr)
                     `HSW_ADDR_MODE: mode_q  <= cmd_wdata[5:0];
                     `HSW_ADDR_TCL:  tc_lin  <= cmd_wdata[7:0];
                     `HSW_ADDR_TCQ:  tc_quad <= cmd_wdata[7:0];
                     `HSW_ADDR_GAIN: gain_q  <= cmd_wdata[13:0];
                     `HSW_ADDR_QOFS: qofs_q  <= cmd_wdata[10:0];
                     `HSW_ADDR_LOW:  low_q   <= cmd_wdata[11:0];
                     default:        high_q  <= cmd_wdata[11:0];
                  endcase
               end
               if (cmd_take & ~cmd_write) begin
                  ans_shift_q <= rd_word;
                  ans_cnt_q   <= `HSW_ANS_BITS;
                  ans_tmr_q   <= ANS_BIT_CYC[15:0] - 16'h0001;
                  state_q     <= ST_ANS;
               end
            end
            ST_ANS: begin
               // Bits go out MSB first, ANS_BIT_CYC cycles each.
               // The word is frozen at the take, so later writes or filter
               // updates cannot tear a reply in progress.
               if (ans_tmr_q != 16'h0000) begin
                  ans_tmr_q <= ans_tmr_q - 16'h0001;
               end else if (ans_cnt_q == 5'h01) begin
                  ans_cnt_q <= 5'h00;
                  state_q   <= ST_RUN;
               end else begin
                  ans_cnt_q   <= ans_cnt_q - 5'h01;
                  ans_shift_q <= {ans_shift_q[14:0], 1'b0};
                  ans_tmr_q   <= ANS_BIT_CYC[15:0] - 16'h0001;
               end
            end
            default: begin
               state_q <= ST_LOAD;
            end
         endcase
      end
   end

   // =======================================================================
   // Output pin: answer bits during a reply, idle high while an exchange
   // runs or storage loads, otherwise the comparator.
   // Parking the pin high keeps the programmer from mistaking a switch
   // event for answer data.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         out_level <= 1'b1;
      end else if (state_q[2]) begin
         out_level <= ans_shift_q[15];
      end else if (comm_active | state_q[0]) begin
         out_level <= 1'b1;
      end else begin
         out_level <= sw_q;
      end
   end

endmodule

// ---- hsw_dsp_props.sv ----
`timescale 1ns/1ps
// ====================
// Port checker for load, answer, lock and output rules.
module hsw_dsp_props #(
   parameter ANS_BIT_CYC = 4
) (
   input wire       ref_clk,     // Clock.
   input wire       rst_b,       // Reset.
   input wire       comm_active, // Exchange.
   input wire [2:0] range_sel,   // Range code.
   input wire [7:0] range_mt,    // Range mT.
   input wire [7:0] tc_lin,      // Coeff.
   input wire [7:0] trim_osc,    // Trim.
   input wire [7:0] trim_adc,    // Trim.
   input wire [7:0] trim_spc,    // Trim.
   input wire       out_level,   // Pin.
   input wire       ans_busy,    // Answer.
   input wire       loaded,      // Load done.
   input wire       lock_active  // Lock.
);
   localparam [63:0] MT_TAB = {8'h64, 8'h50, 8'h3C, 8'h28,
                               8'h96, 8'h5A, 8'h4B, 8'h1E};
   localparam [15:0] BUSY_LEN = 16 * ANS_BIT_CYC;
   reg [3:0]  load_cnt_q;
   reg [15:0] busy_cnt_q;
   // Counters saturate or clear so a long run never wraps into a pass.
   always @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         load_cnt_q <= 4'h0;
         busy_cnt_q <= 16'h0000;
      end else begin
         if (load_cnt_q != 4'hF) load_cnt_q <= load_cnt_q + 4'h1;
         busy_cnt_q <= ans_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   property p_load_len; loaded == (load_cnt_q >= 4'hC); endproperty
   a_load_len: assert property (p_load_len) else $error("Load length.");
   property p_out_load; !loaded |-> out_level; endproperty
   a_out_load: assert property (p_out_load) else $error("Early switch.");
   property p_out_comm; (comm_active && !ans_busy)[*3] |-> out_level; endproperty
   a_out_comm: assert property (p_out_comm) else $error("Not parked.");
   property p_range; range_mt == MT_TAB[range_sel*8 +: 8]; endproperty
   a_range: assert property (p_range) else $error("Range decode.");
   property p_lock_keep; lock_active |=> lock_active; endproperty
   a_lock_keep: assert property (p_lock_keep) else $error("Lock cleared.");
   property p_lock_rise; $rose(lock_active) |-> !$past(loaded); endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("Lock early.");
   property p_lock_quiet; lock_active |-> !ans_busy; endproperty
   a_lock_quiet: assert property (p_lock_quiet) else $error("Locked read.");
   property p_tc_locked; lock_active && $past(lock_active) |-> $stable(tc_lin); endproperty
   a_tc_locked: assert property (p_tc_locked) else $error("Locked write.");
   property p_busy_len; $fell(ans_busy) |-> busy_cnt_q == BUSY_LEN; endproperty
   a_busy_len: assert property (p_busy_len) else $error("Answer length.");
   property p_busy_ld; ans_busy |-> loaded; endproperty
   a_busy_ld: assert property (p_busy_ld) else $error("Answer in load.");
   property p_trim_ro; loaded |-> (trim_osc | trim_adc | trim_spc) == 8'h00; endproperty
   a_trim_ro: assert property (p_trim_ro) else $error("Trim written.");
endmodule
bind hsw_dsp hsw_dsp_props #(.ANS_BIT_CYC(ANS_BIT_CYC)) i_hsw_dsp_props (
   .ref_clk(ref_clk), .rst_b(rst_b), .comm_active(comm_active),
   .range_sel(range_sel), .range_mt(range_mt), .tc_lin(tc_lin),
   .trim_osc(trim_osc), .trim_adc(trim_adc), .trim_spc(trim_spc),
   .out_level(out_level), .ans_busy(ans_busy), .loaded(loaded),
   .lock_active(lock_active));

// ---- hsw_prog.sv ----
`timescale 1ns/1ps
// ====================
// Programming station that hands decoded commands to the device.
module hsw_prog #(
   parameter ANS_BIT_CYC = 4
) (
   input  wire        ref_clk,     // Clock.
   input  wire        loaded,      // Device ready.
   input  wire        ans_busy,    // Answer running.
   output reg         comm_active, // Exchange.
   output reg         cmd_valid,   // Strobe.
   output reg         cmd_write,   // Write.
   output reg  [3:0]  cmd_addr,    // Index.
   output reg  [15:0] cmd_wdata    // Data.
);
   integer n;
   // Idle lines at time zero.
   initial begin
      comm_active = 1'b0;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_addr = 4'h0;
      cmd_wdata = 16'h0000;
   end
   // One exchange; released lines flip so a stale value cannot pass.
   task xfer(input w, input [3:0] a, input [15:0] d);
      begin
         n = 0;
         while (loaded !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         @(negedge ref_clk);
         comm_active = 1'b1;
         cmd_valid = 1'b1;
         cmd_write = w;
         cmd_addr = a;
         cmd_wdata = d;
         @(negedge ref_clk);
         cmd_valid = 1'b0;
         cmd_addr = ~a;
         cmd_wdata = ~d;
         n = 0;
         while (!w && ans_busy !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         n = 0;
         while (ans_busy === 1'b1 && n < 16 * ANS_BIT_CYC + 10) begin
            @(negedge ref_clk);
            n = n + 1;
         end
         repeat (3) @(negedge ref_clk);
         comm_active = 1'b0;
      end
   endtask
endmodule

// ---- tb_hall_switch_dsp_comparator.sv ----
`timescale 1ns/1ps
`include "hsw_regs.vh"
// ====================
module tb_hall_switch_dsp_comparator;
   localparam N = 4;
   localparam [63:0] MT = {8'h64, 8'h50, 8'h3C, 8'h28,
                           8'h96, 8'h5A, 8'h4B, 8'h1E};
   reg               ref_clk;
   reg               rst_b;
   reg signed [13:0] adc_sample;
   reg               adc_valid;
   wire              comm_active, cmd_valid, cmd_write;
   wire [3:0]        cmd_addr;
   wire [15:0]       cmd_wdata;
   wire [2:0]        range_sel;
   wire [7:0]        range_mt, tc_lin, tc_quad, trim_osc, trim_adc, trim_spc;
   wire              out_level, ans_busy, loaded, lock_active;
   integer           errors, checks_done, y, k, lo, hi, c, bi, seed;
   logic [15:0]      exp_q [$];
   reg [15:0]        word, r1, r2;
   hsw_dsp #(.ANS_BIT_CYC(N)) i_hsw_dsp (.ref_clk(ref_clk), .rst_b(rst_b),
      .adc_sample(adc_sample), .adc_valid(adc_valid),
      .comm_active(comm_active), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .range_sel(range_sel), .range_mt(range_mt), .tc_lin(tc_lin),
      .tc_quad(tc_quad), .trim_osc(trim_osc), .trim_adc(trim_adc),
      .trim_spc(trim_spc), .out_level(out_level), .ans_busy(ans_busy),
      .loaded(loaded), .lock_active(lock_active));
   hsw_prog #(.ANS_BIT_CYC(N)) i_hsw_prog (.ref_clk(ref_clk),
      .loaded(loaded), .ans_busy(ans_busy), .comm_active(comm_active),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata));
   // Free-running clock.
   always #10 ref_clk = ~ref_clk;
   task chk(input string nm, input [15:0] e, input [15:0] g);
      begin
         checks_done = checks_done + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task test_done;
      begin
         if (errors == 0 && checks_done > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      i_hsw_prog.xfer(1'b1, a, d);
   endtask
   // A read notes its expected word before the command goes out.
   task rd(input [3:0] a, input [15:0] e);
      begin
         exp_q.push_back(e);
         i_hsw_prog.xfer(1'b0, a, 16'h0000);
      end
   endtask
   // Mode write also selects the filter model's shift and clip span.
   task set_mode(input [5:0] m);
      begin
         wr(`HSW_ADDR_MODE, {10'h000, m});
         case (m[5:3])
            3'h0: begin k = 7; lo = -3968; hi = 3967; end
            3'h1: begin k = 6; lo = -1985; hi = 1985; end
            3'h2: begin k = 4; lo = -5292; hi = 5290; end
            3'h3: begin k = 3; lo = -2646; hi = 2645; end
            default: begin k = 2; lo = -1512; hi = 1511; end
         endcase
      end
   endtask
   // Converter words, one filter update per strobe, then pipeline settles.
   task feed(input integer x, input integer cnt);
      repeat (cnt) begin
         @(negedge ref_clk);
         adc_sample = x;
         adc_valid = 1'b1;
         @(negedge ref_clk);
         adc_valid = 1'b0;
         y = y + ((x - y) >>> k);
         if (y > hi) y = hi;
         if (y < lo) y = lo;
      end
      repeat (4) @(negedge ref_clk);
   endtask
   // Serial answer, MSB first, sampled half a cycle into each bit, checked against oldest note.
   initial forever begin
      @(posedge ans_busy);
      @(posedge ref_clk);
      @(negedge ref_clk);
      for (bi = 15; bi >= 0; bi = bi - 1) begin
         word[bi] = out_level;
         repeat (N) @(negedge ref_clk);
      end
      if (exp_q.size() == 0) chk("answer", 16'hDEAD, word);
      else chk("answer", exp_q.pop_front(), word);
   end
   // Watchdog well beyond the expected run of about 10000 cycles.
   initial begin
      #1000000;
      errors = errors + 1;
      test_done;
   end
   // Main sequence.
   initial begin
      ref_clk = 1'b0;
      rst_b = 1'b0;
      adc_sample = 14'sh0000;
      adc_valid = 1'b0;
      errors = 0;
      checks_done = 0;
      y = 0;
      k = 7;
      lo = -3968;
      hi = 3967;
      seed = $urandom(1);
      repeat (2) @(negedge ref_clk);
      rst_b = 1'b1;
      rd(`HSW_ADDR_GAIN, 16'h0000);
      r1 = $urandom & 16'h00FF;
      r2 = $urandom & 16'h00FF;
      wr(`HSW_ADDR_TCL, r1);
      wr(`HSW_ADDR_TCQ, r2);
      chk("tc_lin", r1, {8'h00, tc_lin});
      chk("tc_quad", r2, {8'h00, tc_quad});
      rd(`HSW_ADDR_TCL, r1);
      rd(`HSW_ADDR_TCQ, r2);
      for (c = 9; c < 12; c = c + 1) begin
         wr(c, 16'hFFFF);
         rd(c, 16'h0000);
      end
      rd(4'hC, 16'h0000);
      rd(4'hF, 16'h0000);
      wr(`HSW_ADDR_SAMPLE, 16'h1234);
      rd(`HSW_ADDR_SAMPLE, 16'h0000);
      for (c = 0; c < 8; c = c + 1) begin
         wr(`HSW_ADDR_MODE, c);
         chk("range_sel", c, {13'h0000, range_sel});
         chk("range_mt", MT[c*8 +: 8], {8'h00, range_mt});
      end
      for (c = 0; c < 8; c = c + 1) begin
         set_mode(c << 3);
         feed(8191, 200);
         rd(`HSW_ADDR_SAMPLE, y);
         feed(-8192, 200);
         rd(`HSW_ADDR_SAMPLE, y);
      end
      set_mode(6'h20);
      wr(`HSW_ADDR_GAIN, 16'h0800);
      wr(`HSW_ADDR_QOFS, 16'h0000);
      wr(`HSW_ADDR_LOW, 16'h0064);
      wr(`HSW_ADDR_HIGH, 16'h00C8);
      feed(50, 60);
      chk("out_level", 16'h0001, out_level);
      feed(150, 60);
      chk("out_level", 16'h0001, out_level);
      feed(300, 60);
      chk("out_level", 16'h0000, out_level);
      feed(150, 60);
      chk("out_level", 16'h0000, out_level);
      rd(`HSW_ADDR_GAIN, 16'h0800);
      repeat (4) @(negedge ref_clk);
      chk("out_level", 16'h0000, out_level);
      wr(`HSW_ADDR_GAIN, 16'h3800);
      wr(`HSW_ADDR_QOFS, 16'h01F4);
      wr(`HSW_ADDR_LOW, 16'h02BC);
      wr(`HSW_ADDR_HIGH, 16'h0384);
      feed(-100, 60);
      chk("out_level", 16'h0000, out_level);
      feed(400, 60);
      chk("out_level", 16'h0001, out_level);
      rd(`HSW_ADDR_GAIN, 16'hF800);
      rd(`HSW_ADDR_QOFS, 16'h01F4);
      wr(`HSW_ADDR_LOCK, 16'h0001);
      r1 = $urandom & 16'h00FF;
      wr(`HSW_ADDR_TCL, r1);
      rd(`HSW_ADDR_TCL, r1);
      chk("lock_active", 16'h0000, lock_active);
      @(negedge ref_clk);
      rst_b = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (20) @(negedge ref_clk);
      chk("lock_active", 16'h0001, lock_active);
      chk("tc_lin", r1, {8'h00, tc_lin});
      wr(`HSW_ADDR_TCL, ~r1 & 16'h00FF);
      chk("tc_lin", r1, {8'h00, tc_lin});
      i_hsw_prog.xfer(1'b0, `HSW_ADDR_TCL, 16'h0000);
      repeat (80) @(negedge ref_clk);
      chk("pending", 16'h0000, exp_q.size());
      test_done;
   end
endmodule
